// *** verilog/rdc_pkg.sv ***
// package: register map, field layout, reset values and carrier types of the receive dc / coding config bank
`default_nettype none
package rdc_pkg;

	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [31:0] RDC_DEMOD_CLK_ADDR = 32'h5001_0150;
	localparam logic [31:0] RDC_DC_EST_ADDR    = 32'h5001_0154;
	localparam logic [31:0] RDC_CODING_ADDR    = 32'h5001_0180;
	localparam logic [31:0] RDC_SEED_ADDR      = 32'h5001_0184;

	// ****************************************
	// field positions
	// ****************************************
	localparam int RDC_INT_SET_LSB   = 0;
	localparam int RDC_CLK_PHASE_LSB = 3;
	localparam int RDC_CLK_SRC_BIT   = 6;
	localparam int RDC_DC_FIX_LSB    = 0;
	localparam int RDC_DC_MODE_LSB   = 8;
	localparam int RDC_CRC_EN_BIT    = 0;
	localparam int RDC_FEC_EN_BIT    = 1;
	localparam int RDC_WHT_EN_BIT    = 2;
	localparam int RDC_CRC_POL_BIT   = 3;
	localparam int RDC_ID_LEN_BIT    = 16;
	localparam int RDC_TOL1_LSB      = 17;
	localparam int RDC_TOL2_LSB      = 20;
	localparam int RDC_SEED_LSB      = 0;

	// ****************************************
	// encodings and reset values
	// ****************************************
	localparam logic [1:0] RDC_DC_MODE_FIXED = 2'h0;
	localparam logic [1:0] RDC_DC_MODE_HOLD  = 2'h1;
	localparam logic [2:0] RDC_PHASE_RST     = 3'h2;
	localparam logic [7:0] RDC_DC_FIX_RST    = 8'h80;
	localparam logic [1:0] RDC_DC_MODE_RST   = RDC_DC_MODE_HOLD;

	// averaging windows in received bits
	localparam int RDC_PRE_SYNC_BITS  = 32;
	localparam int RDC_POST_SYNC_BITS = 128;
	localparam int RDC_PRE_LOG2       = $clog2(RDC_PRE_SYNC_BITS);
	localparam int RDC_POST_LOG2      = $clog2(RDC_POST_SYNC_BITS);

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic       rx_clk_source_sel;
		logic [2:0] recovered_clk_phase;
		logic [2:0] internal_demod_setting;
		logic [7:0] dc_fixed_level;
		logic [1:0] dc_estimation_mode;
		logic       crc_polarity_flip;
		logic       whitening_enable;
		logic       fec_enable;
		logic       crc_enable;
		logic       sync_word_length_sel;
		logic [2:0] first_word_err_tolerance;
		logic [2:0] second_word_err_tolerance;
		logic [6:0] whitening_seed;
	} rdc_cfg_s;

	typedef struct packed {
		rdc_cfg_s    cfg;
		logic [31:0] prdata;
		logic        synced;
		logic [7:0]  dc_est;
		logic        match;
		logic        match_valid;
	} rdc_top_s;

endpackage
`default_nettype wire

// *** verilog/rdc_dc_avg.sv ***
// module: block averager of 8-bit demodulator samples over 2**LOG2N bits
`timescale 1ns/10ps
`default_nettype none
module rdc_dc_avg
	import rdc_pkg::*;
#(
	parameter int LOG2N = 5
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       clr_i,
	input  wire logic       en_i,
	input  wire logic [7:0] sample_i,
	output logic      [7:0] mean_o,
	output logic            done_o
);

	typedef struct packed {
		logic [LOG2N-1:0] cnt;
		logic [LOG2N+7:0] sum;
		logic [7:0]       mean;
		logic             done;
	} rdc_avg_s;

	rdc_avg_s q;
	rdc_avg_s next_q;
	logic [LOG2N+7:0] sum_add;

	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		sum_add = q.sum + {{LOG2N{1'b0}}, sample_i};
		if (clr_i) begin
			next_q.cnt = '0;
			next_q.sum = '0;
		end else if (en_i) begin
			next_q.cnt = q.cnt + 1'b1;
			next_q.sum = sum_add;
			// mean is a shift: window is a power of two
			if (&q.cnt) begin
				next_q.mean = sum_add[LOG2N+7:LOG2N];
				next_q.sum = '0;
				next_q.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign mean_o = q.mean;
	assign done_o = q.done;

endmodule // rdc_dc_avg
`default_nettype wire

// *** verilog/rdc_id_match.sv ***
// module: sync word comparator with a bit error tolerance
`timescale 1ns/10ps
`default_nettype none
module rdc_id_match
	import rdc_pkg::*;
(
	input  wire logic [31:0] rx_word_i,
	input  wire logic [31:0] exp_word_i,
	input  wire logic [2:0]  tol_i,
	output logic             ok_o
);

	logic [5:0] errs;

	always_comb begin
		errs = 6'h00;
		for (int i = 0; i < 32; i++) begin
			errs = errs + {5'h00, rx_word_i[i] ^ exp_word_i[i]};
		end
	end

	assign ok_o = (errs <= {3'h0, tol_i});

endmodule // rdc_id_match
`default_nettype wire

// *** verilog/rdc_cfg_top.sv ***
// module: apb register bank for receive dc estimation and packet coding, with dc estimator and sync word check
//
// Contract
// - rx clock source: 0 virtual, 1 recovered
// - three-bit recovered clock phase, recommended 010
// - mode 00 uses programmed fixed dc level
// - mode 01 averages 32 bits, holds after sync
// - mode 1x switches to 128-bit average after sync
// - low dc byte reads estimate; writes keep it
// - crc polarity flip inverts crc field
// - whitening, fec, crc enables on bits 2..0
// - second word tolerance 0 to 7 errors
// - second word checked only for eight-byte id
// - first word tolerance 0 to 7 errors
// - id length select: 0 four, 1 eight bytes
// - seven-bit whitening seed
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rdc_cfg_top
	import rdc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// demodulator side
	input  wire logic        rx_active_i,
	input  wire logic        bit_valid_i,
	input  wire logic [7:0]  dc_sample_i,
	input  wire logic        frame_sync_i,
	output logic      [7:0]  dc_level_o,
	// sync word check
	input  wire logic        word_valid_i,
	input  wire logic [31:0] rx_first_word_i,
	input  wire logic [31:0] rx_second_word_i,
	input  wire logic [31:0] sync_word_first_half_i,
	input  wire logic [31:0] sync_word_second_half_i,
	output logic             match_valid_o,
	output logic             sync_word_match_o,
	// configuration to the coding and demodulator paths
	output rdc_cfg_s         cfg_o
);

	// ****************************************
	// state and helpers
	// ****************************************
	rdc_top_s q;
	rdc_top_s next_q;

	logic       setup;
	logic       access;
	logic       wr;
	logic       mapped;
	logic       avg_pre_en;
	logic       avg_pre_clr;
	logic       avg_post_en;
	logic       avg_post_clr;
	logic [7:0] mean_pre;
	logic [7:0] mean_post;
	logic       done_pre;
	logic       done_post;
	logic       first_ok;
	logic       second_ok;

	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign wr     = access & pwrite;

	always_comb begin
		if (paddr == RDC_DEMOD_CLK_ADDR) begin
			mapped = 1'b1;
		end else if (paddr == RDC_DC_EST_ADDR) begin
			mapped = 1'b1;
		end else if (paddr == RDC_CODING_ADDR) begin
			mapped = 1'b1;
		end else if (paddr == RDC_SEED_ADDR) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// ****************************************
	// averagers
	// ****************************************
	// pre-sync window keeps running until sync so the held value is the freshest one
	assign avg_pre_en   = bit_valid_i & rx_active_i & ~q.synced;
	assign avg_pre_clr  = ~rx_active_i;
	assign avg_post_en  = bit_valid_i & q.synced & q.cfg.dc_estimation_mode[1];
	assign avg_post_clr = ~q.synced;

	rdc_dc_avg #(
		.LOG2N (RDC_PRE_LOG2)
	) u_avg_pre (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.clr_i    (avg_pre_clr),
		.en_i     (avg_pre_en),
		.sample_i (dc_sample_i),
		.mean_o   (mean_pre),
		.done_o   (done_pre)
	);

	rdc_dc_avg #(
		.LOG2N (RDC_POST_LOG2)
	) u_avg_post (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.clr_i    (avg_post_clr),
		.en_i     (avg_post_en),
		.sample_i (dc_sample_i),
		.mean_o   (mean_post),
		.done_o   (done_post)
	);

	// ****************************************
	// sync word comparators
	// ****************************************
	rdc_id_match u_match_first (
		.rx_word_i  (rx_first_word_i),
		.exp_word_i (sync_word_first_half_i),
		.tol_i      (q.cfg.first_word_err_tolerance),
		.ok_o       (first_ok)
	);

	rdc_id_match u_match_second (
		.rx_word_i  (rx_second_word_i),
		.exp_word_i (sync_word_second_half_i),
		.tol_i      (q.cfg.second_word_err_tolerance),
		.ok_o       (second_ok)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_q = q;
		next_q.match_valid = 1'b0;

		// read data is captured in setup, so the access phase needs no wait
		if (setup) begin
			if (paddr == RDC_DC_EST_ADDR) begin
				next_q.prdata = {22'h000000, q.cfg.dc_estimation_mode, q.dc_est};
			end else begin
				next_q.prdata = 32'h0000_0000;
			end
		end

		if (wr) begin
			if (paddr == RDC_DEMOD_CLK_ADDR) begin
				next_q.cfg.rx_clk_source_sel = pwdata[RDC_CLK_SRC_BIT];
				next_q.cfg.recovered_clk_phase = pwdata[RDC_CLK_PHASE_LSB +: 3];
				next_q.cfg.internal_demod_setting = pwdata[RDC_INT_SET_LSB +: 3];
			end else if (paddr == RDC_DC_EST_ADDR) begin
				// the low byte holds the fixed level only; the estimate is not writable
				next_q.cfg.dc_fixed_level = pwdata[RDC_DC_FIX_LSB +: 8];
				next_q.cfg.dc_estimation_mode = pwdata[RDC_DC_MODE_LSB +: 2];
			end else if (paddr == RDC_CODING_ADDR) begin
				next_q.cfg.crc_polarity_flip = pwdata[RDC_CRC_POL_BIT];
				next_q.cfg.whitening_enable = pwdata[RDC_WHT_EN_BIT];
				next_q.cfg.fec_enable = pwdata[RDC_FEC_EN_BIT];
				next_q.cfg.crc_enable = pwdata[RDC_CRC_EN_BIT];
				next_q.cfg.sync_word_length_sel = pwdata[RDC_ID_LEN_BIT];
				next_q.cfg.first_word_err_tolerance = pwdata[RDC_TOL1_LSB +: 3];
				next_q.cfg.second_word_err_tolerance = pwdata[RDC_TOL2_LSB +: 3];
			end else if (paddr == RDC_SEED_ADDR) begin
				next_q.cfg.whitening_seed = pwdata[RDC_SEED_LSB +: 7];
			end
		end

		// frame tracking: sync found until the receiver leaves rx
		if (!rx_active_i) begin
			next_q.synced = 1'b0;
		end else if (frame_sync_i) begin
			next_q.synced = 1'b1;
		end

		// estimate update per mode
		if (q.cfg.dc_estimation_mode == RDC_DC_MODE_FIXED) begin
			next_q.dc_est = q.cfg.dc_fixed_level;
		end else if (!q.synced && done_pre) begin
			next_q.dc_est = mean_pre;
		end else if (q.synced && q.cfg.dc_estimation_mode[1] && done_post) begin
			next_q.dc_est = mean_post;
		end

		if (word_valid_i) begin
			next_q.match_valid = 1'b1;
			next_q.match = first_ok & (~q.cfg.sync_word_length_sel | second_ok);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
			q.cfg.recovered_clk_phase <= RDC_PHASE_RST;
			q.cfg.dc_fixed_level <= RDC_DC_FIX_RST;
			q.cfg.dc_estimation_mode <= RDC_DC_MODE_RST;
			q.dc_est <= RDC_DC_FIX_RST;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata            = q.prdata;
	assign pready            = access;
	assign pslverr           = access & ~mapped;
	assign cfg_o             = q.cfg;
	assign match_valid_o     = q.match_valid;
	assign sync_word_match_o = q.match;
	// fixed mode bypasses the estimate at once, not one cycle later
	assign dc_level_o = (q.cfg.dc_estimation_mode == RDC_DC_MODE_FIXED) ? q.cfg.dc_fixed_level : q.dc_est;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	AST_CLK_SRC: assert property (
		wr && paddr == RDC_DEMOD_CLK_ADDR |=> cfg_o.rx_clk_source_sel == $past(pwdata[6])
	) else $error("clock source select not loaded");

	AST_PHASE: assert property (
		wr && paddr == RDC_DEMOD_CLK_ADDR |=> cfg_o.recovered_clk_phase == $past(pwdata[5:3])
	) else $error("recovered clock phase not loaded");

	AST_FIXED: assert property (
		cfg_o.dc_estimation_mode == RDC_DC_MODE_FIXED |=> q.dc_est == $past(cfg_o.dc_fixed_level)
	) else $error("estimate does not track fixed level in fixed mode");

	AST_HOLD: assert property (
		cfg_o.dc_estimation_mode == 2'h1 && q.synced && $past(q.synced)
		&& $stable(cfg_o.dc_estimation_mode) |-> $stable(dc_level_o)
	) else $error("estimate moved after sync in hold mode");

	AST_POST_AVG: assert property (
		q.synced && cfg_o.dc_estimation_mode[1] && done_post |=> dc_level_o == $past(mean_post)
	) else $error("post-sync average not applied");

	AST_READBACK: assert property (
		setup && paddr == RDC_DC_EST_ADDR ##1 access |-> prdata[7:0] == $past(q.dc_est)
		&& prdata[31:10] == 22'h000000
	) else $error("dc readback wrong");

	AST_CODING: assert property (
		wr && paddr == RDC_CODING_ADDR |=> {cfg_o.crc_polarity_flip, cfg_o.whitening_enable,
		cfg_o.fec_enable, cfg_o.crc_enable} == $past(pwdata[3:0])
	) else $error("coding enables not loaded");

	AST_SHORT_ID: assert property (
		word_valid_i && !cfg_o.sync_word_length_sel |=> sync_word_match_o == $past(first_ok)
		&& match_valid_o
	) else $error("second word checked for short id");

	AST_SEED: assert property (
		wr && paddr == RDC_SEED_ADDR |=> cfg_o.whitening_seed == $past(pwdata[6:0])
	) else $error("whitening seed not loaded");

	AST_TOL: assert property (
		word_valid_i |=> sync_word_match_o == ($countones($past(rx_first_word_i) ^ $past(sync_word_first_half_i))
		<= $past(cfg_o.first_word_err_tolerance)) || !sync_word_match_o
	) else $error("word accepted beyond tolerance");

	// ****************************************
	// checks: sync word comparators
	// ****************************************
	// counted here, where a clock exists, rather than inside the comparator
	AST_MATCH_FIRST: assert property (
		first_ok == ($countones(rx_first_word_i ^ sync_word_first_half_i) <= cfg_o.first_word_err_tolerance)
	) else $error("first word comparator disagrees with error count");

	AST_MATCH_SECOND: assert property (
		second_ok == ($countones(rx_second_word_i ^ sync_word_second_half_i) <= cfg_o.second_word_err_tolerance)
	) else $error("second word comparator disagrees with error count");

	AST_LONG_ID: assert property (
		word_valid_i && cfg_o.sync_word_length_sel |=> sync_word_match_o ==
		(($countones($past(rx_first_word_i) ^ $past(sync_word_first_half_i)) <= $past(cfg_o.first_word_err_tolerance))
		&& ($countones($past(rx_second_word_i) ^ $past(sync_word_second_half_i))
		<= $past(cfg_o.second_word_err_tolerance)))
	) else $error("eight-byte id not matched on both words");

	AST_MATCH_VALID: assert property (
		match_valid_o == $past(word_valid_i)
	) else $error("match strobe not one cycle after word");

	// ****************************************
	// checks: register loads and retention
	// ****************************************
	AST_CRC_POL: assert property (
		wr && paddr == RDC_CODING_ADDR |=> cfg_o.crc_polarity_flip == $past(pwdata[3])
	) else $error("crc polarity not loaded");

	AST_ID_LEN: assert property (
		wr && paddr == RDC_CODING_ADDR |=> cfg_o.sync_word_length_sel == $past(pwdata[16])
	) else $error("id length select not loaded");

	AST_TOLS_LOAD: assert property (
		wr && paddr == RDC_CODING_ADDR
		|=> {cfg_o.second_word_err_tolerance, cfg_o.first_word_err_tolerance} == $past(pwdata[22:17])
	) else $error("error tolerances not loaded");

	AST_DC_LOAD: assert property (
		wr && paddr == RDC_DC_EST_ADDR |=> cfg_o.dc_fixed_level == $past(pwdata[7:0])
		&& cfg_o.dc_estimation_mode == $past(pwdata[9:8])
	) else $error("fixed level or mode not loaded");

	// a config field may only move on a write to its own register
	AST_CLK_KEEP: assert property (
		!(wr && paddr == RDC_DEMOD_CLK_ADDR) |=> $stable(cfg_o.rx_clk_source_sel)
	) else $error("clock source select changed without a write");

	AST_PHASE_KEEP: assert property (
		!(wr && paddr == RDC_DEMOD_CLK_ADDR) |=> $stable(cfg_o.recovered_clk_phase)
	) else $error("recovered clock phase changed without a write");

	AST_CODING_KEEP: assert property (
		!(wr && paddr == RDC_CODING_ADDR) |=> $stable({cfg_o.whitening_enable, cfg_o.fec_enable, cfg_o.crc_enable})
	) else $error("coding enables changed without a write");

	AST_SEED_KEEP: assert property (
		!(wr && paddr == RDC_SEED_ADDR) |=> $stable(cfg_o.whitening_seed)
	) else $error("whitening seed changed without a write");

	// ****************************************
	// checks: dc estimate tracking
	// ****************************************
	AST_PRE_AVG: assert property (
		!q.synced && cfg_o.dc_estimation_mode != RDC_DC_MODE_FIXED && done_pre |=> q.dc_est == $past(mean_pre)
	) else $error("pre-sync average not applied");

	AST_SYNC_DROP: assert property (
		!rx_active_i |=> !q.synced
	) else $error("frame sync survived leaving rx");

endmodule // rdc_cfg_top
`default_nettype wire

// *** tb/rdc_tx_model.sv ***
// remote transmitter model: dc samples, frame sync and sync words
`timescale 1ns/10ps
`default_nettype none
module rdc_tx_model (
	input  wire logic        clk_i,
	output logic             rx_active_o,
	output logic             bit_valid_o,
	output logic [7:0]       dc_sample_o,
	output logic             frame_sync_o,
	output logic             word_valid_o,
	output logic [31:0]      first_word_o,
	output logic [31:0]      second_word_o
);
	initial begin
		{rx_active_o, bit_valid_o, frame_sync_o, word_valid_o} = 4'h0;
		dc_sample_o = 8'h00;
		first_word_o = 32'h0;
		second_word_o = 32'h0;
	end
	task automatic frame(input logic on);
		@(posedge clk_i);
		rx_active_o <= on;
	endtask
	// sample line flips between bits so a stale level is never taken as data
	task automatic send_bits(input int n, input logic [7:0] lvl);
		repeat (n) begin
			@(posedge clk_i);
			bit_valid_o <= 1'b1;
			dc_sample_o <= lvl;
			@(posedge clk_i);
			bit_valid_o <= 1'b0;
			dc_sample_o <= ~lvl;
		end
	endtask
	task automatic sync_found();
		@(posedge clk_i);
		frame_sync_o <= 1'b1;
		@(posedge clk_i);
		frame_sync_o <= 1'b0;
	endtask
	task automatic send_words(input logic [31:0] w1, input logic [31:0] w2);
		@(posedge clk_i);
		word_valid_o <= 1'b1;
		first_word_o <= w1;
		second_word_o <= w2;
		@(posedge clk_i);
		word_valid_o <= 1'b0;
		first_word_o <= ~w1;
		second_word_o <= ~w2;
	endtask
endmodule // rdc_tx_model
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: apb register checks, dc estimator and sync word matching
`timescale 1ns/10ps
`default_nettype none
module testbench
	import rdc_pkg::*;
;
	logic        clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rdq;
	logic        rderr, rx_act, bit_v, fsync, word_v, match_valid_o, sync_word_match_o;
	logic [7:0]  dc_smp, dc_level_o;
	logic [31:0] w1, w2;
	logic [31:0] exp1 = 32'hA5A5_A5A5;
	logic [31:0] exp2 = 32'h3C3C_3C3C;
	rdc_cfg_s    cfg_o;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cycles = 0;

	rdc_tx_model m (.clk_i(clk_i), .rx_active_o(rx_act), .bit_valid_o(bit_v), .dc_sample_o(dc_smp),
		.frame_sync_o(fsync), .word_valid_o(word_v), .first_word_o(w1), .second_word_o(w2));
	rdc_cfg_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_active_i(rx_act), .bit_valid_i(bit_v), .dc_sample_i(dc_smp), .frame_sync_i(fsync),
		.dc_level_o(dc_level_o), .word_valid_i(word_v), .rx_first_word_i(w1), .rx_second_word_i(w2),
		.sync_word_first_half_i(exp1), .sync_word_second_half_i(exp2), .match_valid_o(match_valid_o),
		.sync_word_match_o(sync_word_match_o), .cfg_o(cfg_o));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// wait ends when pready is seen high; the bench timeout catches a slave that never answers
		do begin
			@(posedge clk_i);
		end while (pready !== 1'b1);
		rdq = prdata;
		rderr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic e);
		xfer(1'b1, a, d);
		check(32'(rderr), 32'(e));
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic e);
		xfer(1'b0, a, 32'h0);
		check(rdq, exp);
		check(32'(rderr), 32'(e));
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic tryword(input logic l, input logic [2:0] t1, input logic [2:0] t2, input int e1, input int e2,
		input logic ex);
		wr(RDC_CODING_ADDR, (32'(l) << RDC_ID_LEN_BIT) | (32'(t1) << RDC_TOL1_LSB) | (32'(t2) << RDC_TOL2_LSB), 1'b0);
		check(32'({cfg_o.sync_word_length_sel, cfg_o.first_word_err_tolerance, cfg_o.second_word_err_tolerance}),
			32'({l, t1, t2}));
		m.send_words(exp1 ^ ((32'h1 << e1) - 1), exp2 ^ ((32'h1 << e2) - 1));
		#1;
		check(32'(match_valid_o), 32'h1);
		check(32'(sync_word_match_o), 32'(ex));
	endtask

	// ****************************************
	// clock, reset, timeout and tests
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		{arst_n_i, psel, penable, pwrite} = 4'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(RDC_DC_EST_ADDR, 32'h0000_0180, 1'b0);
		check(32'(cfg_o.recovered_clk_phase), 32'h2);
		wr(RDC_DC_EST_ADDR, 32'h0000_0180, 1'b0);
		wr(RDC_DEMOD_CLK_ADDR, 32'h0000_0055, 1'b0);
		check(32'({cfg_o.rx_clk_source_sel, cfg_o.recovered_clk_phase, cfg_o.internal_demod_setting}), 32'h55);
		wr(RDC_DEMOD_CLK_ADDR, 32'h0000_002B, 1'b0);
		check(32'({cfg_o.rx_clk_source_sel, cfg_o.recovered_clk_phase, cfg_o.internal_demod_setting}), 32'h2B);
		rd(RDC_DEMOD_CLK_ADDR, 32'h0, 1'b0);
		rd(32'h5001_0158, 32'h0, 1'b1);
		wr(32'h5001_015C, 32'hFFFF_FFFF, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(RDC_CODING_ADDR, 32'h1 << i, 1'b0);
			check(32'({cfg_o.crc_polarity_flip, cfg_o.whitening_enable, cfg_o.fec_enable, cfg_o.crc_enable}),
				32'h1 << i);
		end
		wr(RDC_SEED_ADDR, 32'hFFFF_FFD5, 1'b0);
		check(32'(cfg_o.whitening_seed), 32'h55);
		// hold mode: average before sync, frozen after
		m.frame(1'b1);
		m.send_bits(32, 8'h40);
		settle();
		check(32'(dc_level_o), 32'h40);
		m.sync_found();
		m.send_bits(32, 8'h20);
		settle();
		check(32'(dc_level_o), 32'h40);
		m.frame(1'b0);
		wr(RDC_DC_EST_ADDR, 32'h0000_0211, 1'b0);
		rd(RDC_DC_EST_ADDR, 32'h0000_0240, 1'b0);
		// long window only completes on the 128th bit after sync
		m.frame(1'b1);
		m.send_bits(32, 8'h60);
		settle();
		check(32'(dc_level_o), 32'h60);
		m.sync_found();
		m.send_bits(127, 8'h30);
		settle();
		check(32'(dc_level_o), 32'h60);
		m.send_bits(1, 8'h30);
		settle();
		check(32'(dc_level_o), 32'h30);
		m.frame(1'b0);
		wr(RDC_DC_EST_ADDR, 32'h0000_009C, 1'b0);
		settle();
		check(32'(dc_level_o), 32'h9C);
		tryword(1'b0, 3'h3, 3'h0, 3, 8, 1'b1);
		tryword(1'b0, 3'h3, 3'h0, 4, 0, 1'b0);
		tryword(1'b1, 3'h0, 3'h7, 0, 7, 1'b1);
		tryword(1'b1, 3'h0, 3'h7, 0, 8, 1'b0);
		tryword(1'b1, 3'h7, 3'h0, 7, 0, 1'b1);
		tryword(1'b1, 3'h7, 3'h2, 0, 3, 1'b0);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
